// *** inc/tlc_defs.vh ***
// Register offsets, field positions, reset values and timing counts
`ifndef TLC_DEFS_VH
`define TLC_DEFS_VH

// Register indices; byte address is four times the index
`define TLC_IDX_CTRL        6'h09
`define TLC_IDX_FUNC        6'h0A
`define TLC_IDX_DEEMPH      6'h0C
`define TLC_IDX_EQ          6'h0D
`define TLC_IDX_EYE         6'h0E
`define TLC_IDX_STATUS      6'h10
`define TLC_IDX_ERRCNT      6'h11
`define TLC_IDX_EYECNT      6'h12

// Control register fields
`define TLC_CTRL_SWAP       7
`define TLC_CTRL_POL        6
`define TLC_CTRL_SIGDET     5
`define TLC_CTRL_ARC_DIS    4
`define TLC_CTRL_REGMODE    3
`define TLC_CTRL_PRBS       2
`define TLC_CTRL_EYE        1
`define TLC_CTRL_RST        8'h00

// Function mode field and its codes
`define TLC_FUNC_RST        8'h01
`define TLC_FM_REDRIVE      2'h0
`define TLC_FM_AUTO         2'h1

// De-emphasis register: swing [7:5], de-emphasis [1:0]
`define TLC_DEEMPH_RST      8'h00
`define TLC_DE_0DB          2'h0
`define TLC_DE_M2DB         2'h1
`define TLC_SWING_DEF       3'h0

// Equalizer register: per-lane codes [15:0], mode [17:16]
`define TLC_EQ_RST          18'h28888
`define TLC_EQM_LOW         2'h0
`define TLC_EQM_HIGH        2'h1
`define TLC_EQM_ADAPT       2'h2
`define TLC_EQ_CODE_7P5DB   4'h6
`define TLC_EQ_CODE_10DB    4'h8
`define TLC_EQ_CODE_ADLO    4'h4
`define TLC_EQ_CODE_ADHI    4'hC

// Eye sample phase [3:0]
`define TLC_EYE_RST         4'h4

// Three-level strap codes, two bits each
`define TLC_STRAP_LOW       2'h0
`define TLC_STRAP_HIGH      2'h1

// Input clock period thresholds in system clock cycles
`define TLC_CLK_TIMEOUT     8'd100
`define TLC_RETIME_MAX_PER  8'd30
`define TLC_TERM_MAX_PER    8'd20

`endif

// *** hdl/tlc_lane_check.v ***
// Per-lane PRBS error counter and eye sample accumulator
`timescale 1ns/100ps
module tlc_lane_check (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       sample,
  input  wire       lane_bit,
  input  wire       err_clr,
  input  wire       eye_en,
  input  wire       eye_strobe,
  output reg  [7:0] err_cnt_r,
  output reg  [7:0] eye_cnt_r
);

  reg  [6:0] hist_r;
  reg  [2:0] fill_r;
  wire       expect_bit;
  wire       err_hit;

  // Self-synchronising PRBS7 check: predict from the last seven bits
  assign expect_bit = hist_r[6] ^ hist_r[5];
  assign err_hit    = sample && (fill_r == 3'd7) &&
                      (expect_bit != lane_bit);

  // History fills for seven samples before any error counts
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_r <= 7'h00;
      fill_r <= 3'd0;
    end else if (sample) begin
      hist_r <= {hist_r[5:0], lane_bit};
      if (fill_r != 3'd7)
        fill_r <= fill_r + 3'd1;
    end
  end

  // Saturating count; an error in the clear cycle still counts
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      err_cnt_r <= 8'h00;
    else if (err_clr)
      err_cnt_r <= err_hit ? 8'h01 : 8'h00;
    else if (err_hit && err_cnt_r != 8'hFF)
      err_cnt_r <= err_cnt_r + 8'h01;
  end

  // Eye accumulator counts ones at the chosen phase
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      eye_cnt_r <= 8'h00;
    else if (!eye_en)
      eye_cnt_r <= 8'h00;
    else if (eye_strobe && lane_bit && eye_cnt_r != 8'hFF)
      eye_cnt_r <= eye_cnt_r + 8'h01;
  end

endmodule

// *** hdl/tlc_lane_ctrl.v ***
// Lane swap, polarity, mode, equalizer and debug control of a retimer
//
// Contract
// - Swap routes lane2 to clock, 1 to 0, 0 to 1, clock to lane2.
// - Swap touches inputs only and works in both modes.
// - Per-lane equalizer codes follow the swapped lane mapping.
// - Swap/polarity strap high inverts every lane's received polarity.
// - Polarity inversion applies only while retiming.
// - Register-selected inversion is honoured only while retiming.
// - Each data lane has an error checker with a readable count.
// - Eye data is captured per data lane and readable over the bus.
// - PRBS drives data outputs, paced by the supplied input clock.
// - Equalizer strap: high fixed 10 dB, low 7.5 dB, floating adaptive.
// - Adaptive gain follows detected rate; registers may choose others.
// - With detection on, input terminations connect only after a valid clock.
// - Detection on without clock: standby, recovery off, pins high-Z.
// - Detection enabled by strap or register, disabled by default.
// - Audio input passes to return output, on by default, can disable.
// - Termination strap: high off, low on, floating on above 2 Gbps.
// - De-emphasis from strap, or register field where 01 gives -2 dB.
// - Swing field 011 with de-emphasis 01 raises the swing.
// - De-emphasis only while retiming; none while redriving.
// - Automatic mode redrives at low rate and retimes above it.
// - Function mode 00 forces redriving over the whole range.
`timescale 1ns/100ps
`include "tlc_defs.vh"
module tlc_lane_ctrl (
  input  wire        sys_clk,
  input  wire        arst_n,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        input_data_lane0,
  input  wire        input_data_lane1,
  input  wire        input_data_lane2,
  input  wire        input_clock_lane,
  input  wire        swap_polarity_strap,
  input  wire [1:0]  equalizer_select_strap,
  input  wire        signal_detect_strap,
  input  wire [1:0]  termination_select_strap,
  input  wire        deemphasis_strap,
  input  wire        register_enable_strap,
  input  wire        spdif_input,
  output wire        output_data_lane0,
  output wire        output_data_lane1,
  output wire        output_data_lane2,
  output wire        output_clock_lane,
  output wire        output_drive_en,
  output wire        input_term_en,
  output wire        cdr_enable,
  output wire        tx_term_en,
  output wire [3:0]  eq_code_pin0,
  output wire [3:0]  eq_code_pin1,
  output wire [3:0]  eq_code_pin2,
  output wire [3:0]  eq_code_pin3,
  output wire [1:0]  deemph_code,
  output wire [2:0]  swing_code,
  output wire        audio_return_output
);

  // Physical input index that feeds logical lane idx (self-inverse)
  function [1:0] map_src;
    input integer idx;
    input         swap;
    begin
      if (!swap)
        map_src = idx[1:0];
      else begin
        case (idx)
          0:       map_src = 2'd1;
          1:       map_src = 2'd0;
          2:       map_src = 2'd3;
          default: map_src = 2'd2;
        endcase
      end
    end
  endfunction

  // Merge write data into a register under the byte enables
  function [31:0] be_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  be;
    integer      b;
    begin
      be_merge = old_v;
      for (b = 0; b < 4; b = b + 1)
        if (be[b])
          be_merge[b*8 +: 8] = new_v[b*8 +: 8];
    end
  endfunction

  // Reset release through two flops
  reg  [1:0]  rst_sync_r;
  wire        rst_n;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // Pin synchronisers; only the second stage is read by logic
  wire [13:0] pin_raw;
  reg  [13:0] pin_s1_r;
  reg  [13:0] pin_s2_r;
  assign pin_raw = {register_enable_strap, deemphasis_strap,
                    termination_select_strap, equalizer_select_strap,
                    signal_detect_strap, swap_polarity_strap,
                    spdif_input, input_clock_lane, input_data_lane2,
                    input_data_lane1, input_data_lane0, 1'b0};
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 14'h0000;
      pin_s2_r <= 14'h0000;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  wire [3:0]  phys_in   = pin_s2_r[4:1];
  wire        spdif_s   = pin_s2_r[5];
  wire        swp_strap = pin_s2_r[6];
  wire        sd_strap  = pin_s2_r[7];
  wire [1:0]  eq_strap  = pin_s2_r[9:8];
  wire [1:0]  tt_strap  = pin_s2_r[11:10];
  wire        de_strap  = pin_s2_r[12];
  wire        reg_if_en = pin_s2_r[13];

  // Software registers
  reg  [7:0]  ctrl_r;
  reg  [7:0]  func_r;
  reg  [7:0]  deemph_r;
  reg  [17:0] eq_r;
  reg  [3:0]  eye_ph_r;
  reg         wait_r;
  reg  [31:0] rdata_r;
  reg         err_clr_r;

  wire        bus_req = avs_read | avs_write;
  wire        wr_go   = avs_write & ~wait_r;
  wire [5:0]  reg_idx = avs_address[7:2];
  wire [31:0] wr_ctrl = be_merge({24'h0, ctrl_r}, avs_writedata,
                                 avs_byteenable);
  wire [31:0] wr_func = be_merge({24'h0, func_r}, avs_writedata,
                                 avs_byteenable);
  wire [31:0] wr_de   = be_merge({24'h0, deemph_r}, avs_writedata,
                                 avs_byteenable);
  wire [31:0] wr_eq   = be_merge({14'h0, eq_r}, avs_writedata,
                                 avs_byteenable);
  wire [31:0] wr_eye  = be_merge({28'h0, eye_ph_r}, avs_writedata,
                                 avs_byteenable);

  // Register precedence: with the interface on and the register-mode bit set, registers beat straps
  // register over strap
  wire        reg_mode  = reg_if_en & ctrl_r[`TLC_CTRL_REGMODE];
  wire        swap_act  = reg_mode ? ctrl_r[`TLC_CTRL_SWAP] : ~swp_strap;
  wire        sd_en     = reg_mode ? ctrl_r[`TLC_CTRL_SIGDET] : sd_strap;

  // Link clock observation on the logical clock lane
  reg         clk_prev_r;
  reg  [7:0]  per_cnt_r;
  reg  [7:0]  period_r;
  reg         clk_valid_r;
  wire [3:0]  log_raw;
  wire        log_clk   = log_raw[3];
  wire        clk_rise  = log_clk & ~clk_prev_r;
  wire        fast_rate = clk_valid_r && (period_r <= `TLC_RETIME_MAX_PER);
  wire        term_rate = clk_valid_r && (period_r <= `TLC_TERM_MAX_PER);

  // Period between rising edges; timeout marks the clock invalid
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_r  <= 1'b0;
      // Start as timed out so one stray edge never validates the clock
      per_cnt_r   <= `TLC_CLK_TIMEOUT;
      period_r    <= 8'hFF;
      clk_valid_r <= 1'b0;
    end else begin
      clk_prev_r <= log_clk;
      if (clk_rise) begin
        per_cnt_r   <= 8'h01;
        period_r    <= per_cnt_r;
        clk_valid_r <= (per_cnt_r < `TLC_CLK_TIMEOUT);
      end else if (per_cnt_r >= `TLC_CLK_TIMEOUT) begin
        clk_valid_r <= 1'b0;
      end else begin
        per_cnt_r <= per_cnt_r + 8'h01;
      end
    end
  end

  wire        standby   = sd_en & ~clk_valid_r;
  wire [1:0]  fmode     = func_r[1:0];
  wire        retime    = ~standby & ((fmode == `TLC_FM_REDRIVE) ? 1'b0 :
                          (fmode == `TLC_FM_AUTO) ? fast_rate : 1'b1);
  wire        pol_sel   = reg_mode ? ctrl_r[`TLC_CTRL_POL] : swp_strap;
  wire        pol_act   = pol_sel & retime;

  // Lane remap from physical inputs; mode-independent, inputs only
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_map
      assign log_raw[gi] = phys_in[map_src(gi, swap_act)];
    end
  endgenerate
  wire [3:0]  log_data  = log_raw ^ {4{pol_act}};

  // Eye sampling phase counter after each clock rise
  reg  [3:0]  ph_cnt_r;
  wire        eye_strobe = (ph_cnt_r == eye_ph_r);
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      ph_cnt_r <= 4'h0;
    else if (clk_rise)
      ph_cnt_r <= 4'h0;
    else if (ph_cnt_r != 4'hF)
      ph_cnt_r <= ph_cnt_r + 4'h1;
  end

  // Pattern generator steps once per input clock rise
  reg  [6:0]  lfsr_r;
  wire        prbs_on = ctrl_r[`TLC_CTRL_PRBS];
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      lfsr_r <= 7'h7F;
    else if (prbs_on && clk_rise)
      lfsr_r <= {lfsr_r[5:0], lfsr_r[6] ^ lfsr_r[5]};
  end

  // Per-lane checkers see the remapped, polarity-corrected data
  wire [7:0]  err_cnt [0:2];
  wire [7:0]  eye_cnt [0:2];
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_chk
      tlc_lane_check u_chk (
        .clk        (sys_clk),
        .rst_n      (rst_n),
        .sample     (clk_rise),
        .lane_bit   (log_data[gi]),
        .err_clr    (err_clr_r),
        .eye_en     (ctrl_r[`TLC_CTRL_EYE]),
        .eye_strobe (eye_strobe),
        .err_cnt_r  (err_cnt[gi]),
        .eye_cnt_r  (eye_cnt[gi])
      );
    end
  endgenerate

  // Equalizer code per logical lane
  reg  [3:0]  eq_log [0:3];
  integer     li;
  always @* begin
    for (li = 0; li < 4; li = li + 1) begin
      if (reg_mode && eq_r[17:16] == 2'h3)
        eq_log[li] = eq_r[li*4 +: 4];
      else begin
        case (reg_mode ? eq_r[17:16] : eq_strap)
          `TLC_EQM_LOW:  eq_log[li] = `TLC_EQ_CODE_7P5DB;
          `TLC_EQM_HIGH: eq_log[li] = `TLC_EQ_CODE_10DB;
          default:       eq_log[li] = fast_rate ? `TLC_EQ_CODE_ADHI :
                                                  `TLC_EQ_CODE_ADLO;
        endcase
      end
    end
  end

  // Termination and de-emphasis selection
  reg         tx_term_nxt;
  reg  [1:0]  de_nxt;
  always @* begin
    case (tt_strap)
      `TLC_STRAP_HIGH: tx_term_nxt = 1'b0;
      `TLC_STRAP_LOW:  tx_term_nxt = 1'b1;
      default:         tx_term_nxt = term_rate;
    endcase
    if (!retime)
      de_nxt = `TLC_DE_0DB;
    else if (reg_mode)
      de_nxt = deemph_r[1:0];
    else
      de_nxt = de_strap ? `TLC_DE_0DB : `TLC_DE_M2DB;
  end

  // Registered pin outputs
  reg  [3:0]  out_r;
  reg         drv_en_r;
  reg         term_en_r;
  reg         cdr_en_r;
  reg         tx_term_r;
  reg  [15:0] eq_pin_r;
  reg  [1:0]  de_r;
  reg  [2:0]  swing_r;
  reg         arc_r;
  integer     pj;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_r     <= 4'h0;
      drv_en_r  <= 1'b0;
      term_en_r <= 1'b0;
      cdr_en_r  <= 1'b0;
      tx_term_r <= 1'b0;
      eq_pin_r  <= 16'h0000;
      de_r      <= 2'h0;
      swing_r   <= 3'h0;
      arc_r     <= 1'b0;
    end else begin
      out_r[3] <= log_data[3];
      out_r[2:0] <= prbs_on ? lfsr_r[6:4] : log_data[2:0];
      drv_en_r  <= ~standby;
      term_en_r <= ~standby;
      cdr_en_r  <= retime;
      tx_term_r <= tx_term_nxt;
      for (pj = 0; pj < 4; pj = pj + 1)
        eq_pin_r[pj*4 +: 4] <= eq_log[map_src(pj, swap_act)];
      de_r      <= de_nxt;
      swing_r   <= reg_mode ? deemph_r[7:5] : `TLC_SWING_DEF;
      arc_r     <= spdif_s & ~ctrl_r[`TLC_CTRL_ARC_DIS];
    end
  end

  // Bus slave: one wait cycle, then answer for one cycle
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      wait_r <= 1'b1;
    else
      wait_r <= ~(bus_req & wait_r);
  end

  // Register writes take effect at the edge that sees wait low
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r    <= `TLC_CTRL_RST;
      func_r    <= `TLC_FUNC_RST;
      deemph_r  <= `TLC_DEEMPH_RST;
      eq_r      <= `TLC_EQ_RST;
      eye_ph_r  <= `TLC_EYE_RST;
      err_clr_r <= 1'b0;
    end else begin
      err_clr_r <= wr_go && (reg_idx == `TLC_IDX_ERRCNT);
      if (wr_go) begin
        case (reg_idx)
          `TLC_IDX_CTRL:   ctrl_r   <= wr_ctrl[7:0];
          `TLC_IDX_FUNC:   func_r   <= wr_func[7:0];
          `TLC_IDX_DEEMPH: deemph_r <= wr_de[7:0];
          `TLC_IDX_EQ:     eq_r     <= wr_eq[17:0];
          `TLC_IDX_EYE:    eye_ph_r <= wr_eye[3:0];
          default:         ctrl_r   <= ctrl_r;
        endcase
      end
    end
  end

  // Read data is prepared while wait is high; unmapped reads zero
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      rdata_r <= 32'h00000000;
    else if (avs_read && wait_r) begin
      case (reg_idx)
        `TLC_IDX_CTRL:   rdata_r <= {24'h0, ctrl_r};
        `TLC_IDX_FUNC:   rdata_r <= {24'h0, func_r};
        `TLC_IDX_DEEMPH: rdata_r <= {24'h0, deemph_r};
        `TLC_IDX_EQ:     rdata_r <= {14'h0, eq_r};
        `TLC_IDX_EYE:    rdata_r <= {28'h0, eye_ph_r};
        `TLC_IDX_STATUS: rdata_r <= {16'h0, period_r, 4'h0, tx_term_r,
                                     standby, retime, clk_valid_r};
        `TLC_IDX_ERRCNT: rdata_r <= {8'h0, err_cnt[2], err_cnt[1],
                                     err_cnt[0]};
        `TLC_IDX_EYECNT: rdata_r <= {8'h0, eye_cnt[2], eye_cnt[1],
                                     eye_cnt[0]};
        default:         rdata_r <= 32'h00000000;
      endcase
    end
  end

  assign avs_readdata        = rdata_r;
  assign avs_waitrequest     = wait_r;
  assign output_data_lane0   = out_r[0];
  assign output_data_lane1   = out_r[1];
  assign output_data_lane2   = out_r[2];
  assign output_clock_lane   = out_r[3];
  assign output_drive_en     = drv_en_r;
  assign input_term_en       = term_en_r;
  assign cdr_enable          = cdr_en_r;
  assign tx_term_en          = tx_term_r;
  assign eq_code_pin0        = eq_pin_r[3:0];
  assign eq_code_pin1        = eq_pin_r[7:4];
  assign eq_code_pin2        = eq_pin_r[11:8];
  assign eq_code_pin3        = eq_pin_r[15:12];
  assign deemph_code         = de_r;
  assign swing_code          = swing_r;
  assign audio_return_output = arc_r;

endmodule

// *** verification/tlc_lane_chk.sv ***
// Port-level assertions for the lane control block
`timescale 1ns/100ps
module tlc_lane_chk (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic        register_enable_strap,
  input wire logic [1:0]  equalizer_select_strap,
  input wire logic [1:0]  termination_select_strap,
  input wire logic        output_drive_en,
  input wire logic        input_term_en,
  input wire logic        cdr_enable,
  input wire logic        tx_term_en,
  input wire logic [3:0]  eq_code_pin0,
  input wire logic [1:0]  deemph_code
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // Bus: exactly one wait state, idle high after reset
  a_answer_next:
    assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("request not answered next cycle");
  a_wait_one:
    assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("wait request low for more than one cycle");
  a_reset_idle:
    assert property ($rose(arst_n) |-> avs_waitrequest [*2])
      else $error("wait request not idle after reset");
  // Read data must not wander between reads
  a_rdata_hold:
    assert property (!avs_read ##1 !avs_read |-> $stable(avs_readdata))
      else $error("read data changed without a read");
  // Pin behaviour; the repeats allow for synchroniser latency
  a_standby_off:
    assert property (!output_drive_en [*3] |-> !input_term_en && !cdr_enable)
      else $error("standby left termination or recovery on");
  a_redrive_nodeemph:
    assert property (!cdr_enable [*2] |-> deemph_code == 2'h0)
      else $error("de-emphasis applied while redriving");
  a_eq_strap_high:
    assert property (!register_enable_strap && equalizer_select_strap == 2'h1
      [*8] |-> eq_code_pin0 == 4'h8) else $error("strap high gain not used");
  a_term_strap_off:
    assert property (termination_select_strap == 2'h1 [*8] |-> !tx_term_en)
      else $error("transmit termination on with strap high");

  // Main scenarios reached
  c_write: cover property (avs_write && !avs_waitrequest);
  c_retime: cover property ($rose(cdr_enable));
  c_standby: cover property ($fell(output_drive_en));
endmodule

bind tlc_lane_ctrl tlc_lane_chk u_tlc_lane_chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .avs_readdata(avs_readdata), .register_enable_strap(register_enable_strap),
  .equalizer_select_strap(equalizer_select_strap),
  .termination_select_strap(termination_select_strap),
  .output_drive_en(output_drive_en), .input_term_en(input_term_en),
  .cdr_enable(cdr_enable), .tx_term_en(tx_term_en),
  .eq_code_pin0(eq_code_pin0), .deemph_code(deemph_code)
);

// *** verification/tlc_link_src.sv ***
// Upstream source model: link clock and three PRBS7 data lanes
`timescale 1ns/100ps
module tlc_link_src #(
  parameter real HALF_NS = 62.5
) (
  input  wire logic       fix,
  input  wire logic [3:0] fixval,
  input  wire logic       inject,
  output logic            lane0,
  output logic            lane1,
  output logic            lane2,
  output logic            lclk
);
  logic       ph = 1'b0;
  logic       err_r = 1'b0;
  logic       done_r = 1'b0;
  logic [6:0] s0 = 7'h01;
  logic [6:0] s1 = 7'h2A;
  logic [6:0] s2 = 7'h7F;

  // Odd start offset keeps the link phase unrelated to the system clock
  initial begin
    #1.3;
    forever #(HALF_NS) ph = ~ph;
  end

  // Data moves on the falling edge so it is steady at the sampling rise
  always @(negedge ph) begin
    s0 <= {s0[5:0], s0[6] ^ s0[5]};
    s1 <= {s1[5:0], s1[6] ^ s1[5]};
    s2 <= {s2[5:0], s2[6] ^ s2[5]};
    err_r <= inject && !done_r; // One flipped bit per request
    done_r <= inject;
  end

  assign lclk  = fix ? fixval[3] : ph;
  assign lane0 = fix ? fixval[0] : s0[0];
  assign lane1 = fix ? fixval[1] : s1[0] ^ err_r;
  assign lane2 = fix ? fixval[2] : s2[0];
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the lane control block
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  fail_count++; $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest, lane0, lane1, lane2, lclk;
  logic        fix = 1'b1, inject = 1'b0, swap_strap = 1'b0;
  logic        reg_en = 1'b0, spdif = 1'b0;
  logic [3:0]  fixval = 4'h0, eq0, eq1, eq2, eq3;
  logic [1:0]  eq_strap = 2'h1, term_strap = 2'h1, deemph;
  logic        o0, o1, o2, oclk, drive_en, term_en, cdr_en, tx_term, arc;
  logic [2:0]  swing, x3;
  logic [5:0]  ri [6] = '{6'h09, 6'h0A, 6'h0C, 6'h0D, 6'h0E, 6'h3F};
  logic [31:0] rv [6] = '{32'h0, 32'h1, 32'h0, 32'h28888, 32'h4, 32'h0};
  int          fail_count = 0, samples_checked = 0, cyc = 0;

  tlc_lane_ctrl u_tlc_lane_ctrl (
    .sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .input_data_lane0(lane0), .input_data_lane1(lane1),
    .input_data_lane2(lane2), .input_clock_lane(lclk),
    .swap_polarity_strap(swap_strap), .equalizer_select_strap(eq_strap),
    .signal_detect_strap(1'b0), .termination_select_strap(term_strap),
    .deemphasis_strap(1'b1), .register_enable_strap(reg_en),
    .spdif_input(spdif), .output_data_lane0(o0), .output_data_lane1(o1),
    .output_data_lane2(o2), .output_clock_lane(oclk),
    .output_drive_en(drive_en), .input_term_en(term_en),
    .cdr_enable(cdr_en), .tx_term_en(tx_term), .eq_code_pin0(eq0),
    .eq_code_pin1(eq1), .eq_code_pin2(eq2), .eq_code_pin3(eq3),
    .deemph_code(deemph), .swing_code(swing), .audio_return_output(arc)
  );

  tlc_link_src u_tlc_link_src (
    .fix(fix), .fixval(fixval), .inject(inject),
    .lane0(lane0), .lane1(lane1), .lane2(lane2), .lclk(lclk)
  );

  // 200 MHz system clock
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Cuts a hang short; the full run needs under two thousand cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic settle();
    repeat (8) @(posedge sys_clk);
  endtask

  // One Avalon access; held until wait request is seen low
  task automatic bus(input logic we, input logic [5:0] idx,
                     input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= !we;
    @(posedge sys_clk);
    // Only the bench timeout ends a wait that never answers
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rdchk(input logic [5:0] idx, input logic [31:0] m, e);
    bus(1'b0, idx, 32'h0);
    `CHK(rd & m, e)
  endtask

  // Walk a single high level over the four input pins
  task automatic map_chk(input logic sw, input logic inv);
    logic [3:0] v, x;
    for (int i = 0; i < 4; i++) begin
      v = 4'h1 << i;
      x = (sw ? {v[2], v[3], v[0], v[1]} : v) ^ {4{inv}};
      fixval <= v;
      settle();
      `CHK({oclk, o2, o1, o0}, x)
    end
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // Reset values, then an unmapped slot that ignores writes
    for (int i = 0; i < 6; i++) rdchk(ri[i], 32'hFFFFFFFF, rv[i]);
    bus(1'b1, 6'h3F, 32'hFFFFFFFF);
    rdchk(6'h3F, 32'hFFFFFFFF, 32'h0);
    // Strap mode: fixed gains and termination
    `CHK({eq3, eq2, eq1, eq0, tx_term}, 17'h11110)
    eq_strap <= 2'h0;
    term_strap <= 2'h0;
    settle();
    `CHK({eq3, eq2, eq1, eq0, tx_term}, 17'h0CCCD)
    `CHK(drive_en, 1'b1)
    map_chk(1'b1, 1'b0);
    swap_strap <= 1'b1;
    map_chk(1'b0, 1'b0);
    spdif <= 1'b1;
    settle();
    `CHK(arc, 1'b1)
    bus(1'b1, 6'h09, 32'h10);
    settle();
    `CHK(arc, 1'b0)
    // Register mode: forced retime with inversion and de-emphasis
    reg_en <= 1'b1;
    bus(1'b1, 6'h09, 32'h48);
    bus(1'b1, 6'h0A, 32'h2);
    bus(1'b1, 6'h0C, 32'h61);
    settle();
    `CHK({cdr_en, deemph, swing}, 6'b101011)
    map_chk(1'b0, 1'b1);
    bus(1'b1, 6'h09, 32'hC8);
    map_chk(1'b1, 1'b1);
    bus(1'b1, 6'h0A, 32'h0);
    settle();
    `CHK({cdr_en, deemph}, 3'b000)
    map_chk(1'b1, 1'b0);
    // Per-lane gains follow the swapped mapping
    bus(1'b1, 6'h0D, 32'h34321);
    settle();
    `CHK({eq3, eq2, eq1, eq0}, 16'h3412)
    bus(1'b1, 6'h09, 32'h08);
    settle();
    `CHK({eq3, eq2, eq1, eq0}, 16'h4321)
    // Live link in automatic mode at 25 cycles per link period
    fix <= 1'b0;
    term_strap <= 2'h2;
    bus(1'b1, 6'h0A, 32'h1);
    repeat (400) @(posedge sys_clk);
    rdchk(6'h10, 32'hFF07, 32'h1903);
    `CHK({cdr_en, tx_term}, 2'b10)
    rdchk(6'h12, 32'hFFFFFF, 32'h0);
    // Adaptive gain at the fast rate, then eye capture switched on
    bus(1'b1, 6'h0D, 32'h20000);
    bus(1'b1, 6'h09, 32'h0A);
    settle();
    `CHK({eq3, eq2, eq1, eq0}, 16'hCCCC)
    bus(1'b1, 6'h11, 32'h0);
    repeat (300) @(posedge sys_clk);
    rdchk(6'h11, 32'hFFFFFF, 32'h0);
    inject <= 1'b1;
    repeat (60) @(posedge sys_clk);
    inject <= 1'b0;
    repeat (100) @(posedge sys_clk);
    bus(1'b0, 6'h11, 32'h0);
    `CHK({rd[23:16], rd[15:8] != 8'h00, rd[7:0]}, 17'h00100)
    bus(1'b0, 6'h12, 32'h0);
    `CHK({rd[23:16] != 0, rd[15:8] != 0, rd[7:0] != 0}, 3'b111)
    bus(1'b1, 6'h0A, 32'h0);
    settle();
    `CHK(cdr_en, 1'b0)
    // Signal detect: standby without a clock, back up when it returns
    bus(1'b1, 6'h0A, 32'h1);
    bus(1'b1, 6'h09, 32'h28);
    fix <= 1'b1;
    repeat (150) @(posedge sys_clk);
    `CHK({drive_en, term_en, cdr_en}, 3'b000)
    rdchk(6'h10, 32'h7, 32'h4);
    fix <= 1'b0;
    repeat (150) @(posedge sys_clk);
    `CHK({drive_en, term_en}, 2'b11)
    // PRBS: each input clock rise moves the pattern up one lane
    fix <= 1'b1;
    fixval <= 4'h0;
    bus(1'b1, 6'h09, 32'h0C);
    rd = 32'h0;
    for (int i = 0; i < 8; i++) begin
      settle();
      x3 = {o2, o1, o0};
      rd[0] = rd[0] | o2;
      fixval <= 4'h8;
      settle();
      `CHK({o2, o1}, x3[1:0])
      fixval <= 4'h0;
    end
    `CHK(rd[0], 1'b1)
    print_verdict();
  end
endmodule
